// ---- rtl/fex_defines.svh ----
// timing and width constants for the fetch/execute sequencer
`ifndef FEX_DEFINES_SVH
`define FEX_DEFINES_SVH
`define FEX_PHASES 4
`define FEX_DATA_W 8
`define FEX_PC_W 11
`define FEX_IW_W 14
`define FEX_PAGE_W 8
`define FEX_PC_RESET 11'h000
`define FEX_ACC_RESET 8'h00
`endif

// ---- rtl/fex_pkg.sv ----
// types for the fetch/execute sequencer
`default_nettype none
package fex_pkg;
    typedef enum logic [3:0] {
        PH_T1 = 4'h1,
        PH_T2 = 4'h2,
        PH_T3 = 4'h4,
        PH_T4 = 4'h8
    } fex_phase_e;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ALU = 3'h1,
        OP_JUMP = 3'h2,
        OP_SKIP = 3'h3,
        OP_PCL_WR = 3'h4
    } fex_op_e;
    typedef struct packed {
        fex_op_e op;
        logic [3:0] alu_fn;
        logic [7:0] operand;
        logic [10:0] target;
    } fex_dec_s;
endpackage
`default_nettype wire

// ---- rtl/fex_core.sv ----
// four-phase fetch/execute sequencer with 8-bit accumulator alu
// Summary of operation
// (RULE_01) four non-overlapping phase clocks repeat in fixed order from system clock
// (RULE_02) pc advances at start of first phase; next word fetched then
// (RULE_03) decode and execute occupy phases two to four
// (RULE_04) one pass of four phases is one instruction cycle
// (RULE_05) fetch overlaps execute; plain instructions finish one per cycle
// (RULE_06) pc-changing instructions take two cycles: get target, then branch
// (RULE_07) alu works on 8-bit operands; data moves through accumulator
// (RULE_08) taken skip discards prefetched word and runs an idle cycle
// (RULE_09) low pc byte write jumps within 256-word page with idle cycle
// (RULE_10) reset restarts at first phase with no prefetched instruction
`include "fex_defines.svh"
`default_nettype none
module fex_core #(
    parameter int PC_W = `FEX_PC_W,
    parameter int IW_W = `FEX_IW_W
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [IW_W-1:0] IMEM_DATA_I,
    input wire fex_pkg::fex_dec_s DEC_I,
    input wire logic [7:0] OPERAND_I,
    output logic [3:0] PHASE_O,
    output logic [PC_W-1:0] IMEM_ADDR_O,
    output logic IMEM_RD_O,
    output logic [IW_W-1:0] IR_O,
    output logic IR_VALID_O,
    output logic [7:0] ACC_O,
    output logic ALU_ZERO_O,
    output logic ALU_CARRY_O,
    output logic IDLE_CYCLE_O,
    output logic RETIRE_O
);
    if (PC_W <= `FEX_PAGE_W || PC_W > `FEX_PC_W)
    begin : g_bad_pc_w
        $error("fex_core: PC_W must exceed the page width and fit the target field");
    end
    if (IW_W < 1)
    begin : g_bad_iw_w
        $error("fex_core: IW_W must be at least one");
    end

    fex_pkg::fex_phase_e phase, next_phase;
    logic [PC_W-1:0] pc, next_pc;
    logic [PC_W-1:0] fetch_addr, next_fetch_addr;
    logic [IW_W-1:0] ir, next_ir;
    logic ir_valid, next_ir_valid;
    logic [7:0] acc, next_acc;
    logic zero, next_zero, carry, next_carry;
    logic branch_pend, next_branch_pend;
    logic [PC_W-1:0] target, next_target;
    logic idle, next_idle;
    logic retire, next_retire;
    logic exec_now;

    function automatic logic [8:0] alu(input logic [3:0] fn, input logic [7:0] a,
        input logic [7:0] b);
        case (fn)
            4'h0: alu = {1'b0, a} + {1'b0, b};
            4'h1: alu = {1'b0, a} - {1'b0, b};
            4'h2: alu = {1'b0, a & b};
            4'h3: alu = {1'b0, a | b};
            4'h4: alu = {1'b0, a ^ b};
            4'h5: alu = {1'b0, b};
            4'h6: alu = {1'b0, ~a};
            4'h7: alu = {1'b0, a} + 9'h001;
            4'h8: alu = {1'b0, a} - 9'h001;
            4'h9: alu = {a[0], a[0], a[7:1]};
            4'hA: alu = {a[7], a[6:0], a[7]};
            default: alu = {1'b0, a};
        endcase
    endfunction

    function automatic logic [PC_W-1:0] pc_plus_one(input logic [PC_W-1:0] a);
        pc_plus_one = a + {{(PC_W-1){1'b0}}, 1'b1};
    endfunction

    // phase sequencer
    always_comb
    begin
        case (phase)
            fex_pkg::PH_T1:
                next_phase = fex_pkg::PH_T2; // RULE_01
            fex_pkg::PH_T2:
                next_phase = fex_pkg::PH_T3; // RULE_03
            fex_pkg::PH_T3:
                next_phase = fex_pkg::PH_T4;
            fex_pkg::PH_T4:
                next_phase = fex_pkg::PH_T1; // RULE_04
            default:
                next_phase = fex_pkg::PH_T1;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            phase <= fex_pkg::PH_T1; // RULE_10
        else
            phase <= next_phase;
    end

    // execute slot: last phase with a real instruction held
    assign exec_now = (phase == fex_pkg::PH_T4) && ir_valid && !idle; // RULE_03

    // fetch and branch control
    always_comb
    begin
        next_pc = pc;
        next_ir = ir;
        next_ir_valid = ir_valid;
        next_branch_pend = branch_pend;
        next_target = target;
        next_idle = idle;
        if (phase == fex_pkg::PH_T1)
        begin
            next_ir = IMEM_DATA_I; // RULE_02
            next_ir_valid = 1'b1; // RULE_05
            next_idle = 1'b0;
            if (branch_pend)
            begin
                next_pc = target; // RULE_06
                next_ir_valid = 1'b0;
                next_idle = 1'b1;
                next_branch_pend = 1'b0;
            end
            else
                next_pc = pc_plus_one(pc); // RULE_02
        end
        else if (exec_now)
        begin
            case (DEC_I.op)
                fex_pkg::OP_JUMP:
                begin
                    next_target = DEC_I.target[PC_W-1:0]; // RULE_06
                    next_branch_pend = 1'b1;
                end
                fex_pkg::OP_SKIP:
                begin
                    next_target = pc_plus_one(pc); // RULE_08
                    next_branch_pend = 1'b1;
                end
                fex_pkg::OP_PCL_WR:
                begin
                    next_target = {pc[PC_W-1:`FEX_PAGE_W], acc}; // RULE_09
                    next_branch_pend = 1'b1;
                end
                default:
                    next_branch_pend = branch_pend;
            endcase
        end
        next_fetch_addr = next_branch_pend ? next_target : next_pc; // RULE_02
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            pc <= PC_W'(`FEX_PC_RESET);
            fetch_addr <= PC_W'(`FEX_PC_RESET);
            ir <= '0;
            ir_valid <= 1'b0; // RULE_10
            branch_pend <= 1'b0;
            target <= '0;
            idle <= 1'b0;
        end
        else
        begin
            pc <= next_pc;
            fetch_addr <= next_fetch_addr;
            ir <= next_ir;
            ir_valid <= next_ir_valid;
            branch_pend <= next_branch_pend;
            target <= next_target;
            idle <= next_idle;
        end
    end

    // accumulator, flags and retire pulse
    always_comb
    begin
        logic [8:0] res;
        res = 9'h000;
        next_acc = acc;
        next_zero = zero;
        next_carry = carry;
        next_retire = 1'b0;
        if (exec_now)
        begin
            next_retire = 1'b1; // RULE_05
            if (DEC_I.op == fex_pkg::OP_ALU)
            begin
                res = alu(DEC_I.alu_fn, acc, OPERAND_I); // RULE_07
                next_acc = res[7:0];
                next_carry = res[8];
                next_zero = (res[7:0] == 8'h00);
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            acc <= `FEX_ACC_RESET;
            zero <= 1'b0;
            carry <= 1'b0;
            retire <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            zero <= next_zero;
            carry <= next_carry;
            retire <= next_retire;
        end
    end

    assign PHASE_O = phase;
    assign IMEM_ADDR_O = fetch_addr;
    assign IMEM_RD_O = (phase == fex_pkg::PH_T1);
    assign IR_O = ir;
    assign IR_VALID_O = ir_valid && !idle;
    assign ACC_O = acc;
    assign ALU_ZERO_O = zero;
    assign ALU_CARRY_O = carry;
    assign IDLE_CYCLE_O = idle;
    assign RETIRE_O = retire;
endmodule
`default_nettype wire

// ---- tb/fex_core_properties.sv ----
// assertions for the fetch/execute sequencer
`default_nettype none
module fex_core_chk (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire fex_pkg::fex_dec_s DEC_I,
    input wire logic [7:0] OPERAND_I,
    input wire logic [3:0] PHASE_O,
    input wire logic [10:0] IMEM_ADDR_O,
    input wire logic IMEM_RD_O,
    input wire logic IR_VALID_O,
    input wire logic [7:0] ACC_O,
    input wire logic IDLE_CYCLE_O,
    input wire logic RETIRE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire logic ex = PHASE_O == 4'h8 && IR_VALID_O;
    a_phase_order: assert property (PHASE_O == 4'h1 |=> PHASE_O == 4'h2 ##1
        PHASE_O == 4'h4 ##1 PHASE_O == 4'h8 ##1 PHASE_O == 4'h1) else $error("phase order");
    a_fetch_t1: assert property (IMEM_RD_O == (PHASE_O == 4'h1)) else $error("fetch");
    a_retire_t4: assert property (RETIRE_O |-> $past(PHASE_O) == 4'h8)
        else $error("retire");
    a_alu_add: assert property (ex && DEC_I.op == fex_pkg::OP_ALU && DEC_I.alu_fn == 4'h0
        |=> RETIRE_O && ACC_O == $past(ACC_O) + $past(OPERAND_I)) else $error("add");
    a_jump_target: assert property (ex && DEC_I.op == fex_pkg::OP_JUMP
        |=> IMEM_ADDR_O == $past(DEC_I.target) ##1 IDLE_CYCLE_O [*4]) else $error("jump");
    a_skip_idle: assert property (ex && DEC_I.op == fex_pkg::OP_SKIP
        |=> ##1 IDLE_CYCLE_O [*4]) else $error("skip");
    a_skip_target: assert property (ex && DEC_I.op == fex_pkg::OP_SKIP
        |=> IMEM_ADDR_O == $past(IMEM_ADDR_O) + 11'h001) else $error("skip target");
    a_pcl_page: assert property (ex && DEC_I.op == fex_pkg::OP_PCL_WR
        |=> IMEM_ADDR_O == {$past(IMEM_ADDR_O[10:8]), $past(ACC_O)}) else $error("pcl");
    a_idle_quiet: assert property (IDLE_CYCLE_O |-> !RETIRE_O) else $error("idle");
    a_reset_start: assert property ($fell(RST_I) |-> PHASE_O == 4'h1 && !IR_VALID_O)
        else $error("reset");
endmodule
bind fex_core fex_core_chk fex_core_chk_i (.CLK_I(CLK_I), .RST_I(RST_I), .DEC_I(DEC_I),
    .OPERAND_I(OPERAND_I), .PHASE_O(PHASE_O), .IMEM_ADDR_O(IMEM_ADDR_O),
    .IMEM_RD_O(IMEM_RD_O), .IR_VALID_O(IR_VALID_O), .ACC_O(ACC_O),
    .IDLE_CYCLE_O(IDLE_CYCLE_O), .RETIRE_O(RETIRE_O));
`default_nettype wire

// ---- tb/fex_imem.sv ----
// program memory model facing the fetch port
`default_nettype none
module fex_imem (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [10:0] addr_i,
    output logic [13:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] last = 14'h0000;
    always_ff @(posedge clk_i) last <= data_o;
    always_comb data_o = rd_i ? {3'h5, addr_i} : ~last;
endmodule
`default_nettype wire

// ---- tb/fex_core_bench.sv ----
// testbench for the fetch/execute sequencer
`default_nettype none
module fex_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] imem, ir;
    logic [10:0] addr;
    logic [7:0] operand = 8'h00;
    logic [7:0] acc;
    logic [3:0] phase;
    logic rd, irv, zero, carry, idle, retire;
    fex_pkg::fex_dec_s dec = '0;
    int num_errors = 0;
    int compares = 0;
    initial forever #4 clk = ~clk;
    fex_core fex_core_i (.CLK_I(clk), .RST_I(rst), .IMEM_DATA_I(imem), .DEC_I(dec),
        .OPERAND_I(operand), .PHASE_O(phase), .IMEM_ADDR_O(addr), .IMEM_RD_O(rd), .IR_O(ir),
        .IR_VALID_O(irv), .ACC_O(acc), .ALU_ZERO_O(zero), .ALU_CARRY_O(carry),
        .IDLE_CYCLE_O(idle), .RETIRE_O(retire));
    fex_imem fex_imem_i (.clk_i(clk), .rd_i(rd), .addr_i(addr), .data_o(imem));
    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [13:0] e, input logic [13:0] g);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task run(input fex_pkg::fex_op_e op, input logic [3:0] fn, input logic [7:0] b,
        input logic [10:0] t);
        int i;
        for (i = 0; i < 40 && !(phase === 4'h8 && irv === 1'b1); i++) @(negedge clk);
        if (i == 40)
        begin
            num_errors++;
            results();
        end
        dec = '{op, fn, 8'h00, t};
        operand = b;
        @(negedge clk);
        dec.op = fex_pkg::OP_NONE;
    endtask
    task t_alu;
        run(fex_pkg::OP_ALU, 4'h5, 8'hFF, 11'h000);
        chk("acc", 14'h00FF, 14'(acc));
        chk("retire", 14'h0001, 14'(retire));
        chk("rd", 14'h0001, 14'(rd));
        run(fex_pkg::OP_ALU, 4'h0, 8'h01, 11'h000);
        chk("acc", 14'h0000, 14'(acc));
        chk("flags", 14'h0003, 14'({carry, zero}));
    endtask
    task alu_step(input logic [3:0] fn, input logic [7:0] b, input logic [8:0] e);
        run(fex_pkg::OP_ALU, fn, b, 11'h000);
        chk("carry_acc", 14'(e), 14'({carry, acc}));
    endtask
    task t_alu_ops;
        alu_step(4'h5, 8'h3C, 9'h03C);
        alu_step(4'h1, 8'h0C, 9'h030);
        alu_step(4'h2, 8'h1F, 9'h010);
        alu_step(4'h3, 8'h05, 9'h015);
        alu_step(4'h4, 8'hFF, 9'h0EA);
        alu_step(4'h6, 8'h00, 9'h015);
        alu_step(4'h7, 8'h00, 9'h016);
        alu_step(4'h8, 8'h00, 9'h015);
        alu_step(4'h9, 8'h00, 9'h18A);
        alu_step(4'hA, 8'h00, 9'h115);
        alu_step(4'hF, 8'h00, 9'h015);
        alu_step(4'h1, 8'h16, 9'h1FF);
        chk("zero", 14'h0000, 14'(zero));
    endtask
    task t_branch;
        run(fex_pkg::OP_JUMP, 4'h0, 8'h00, 11'h123);
        chk("addr", 14'h0123, 14'(addr));
        @(negedge clk);
        chk("idle", 14'h0001, 14'(idle));
        run(fex_pkg::OP_ALU, 4'h5, 8'h45, 11'h000);
        chk("ir", 14'h2923, ir);
        run(fex_pkg::OP_PCL_WR, 4'h0, 8'h00, 11'h000);
        chk("addr", 14'h0145, 14'(addr));
        run(fex_pkg::OP_SKIP, 4'h0, 8'h00, 11'h000);
        chk("addr", 14'h0147, 14'(addr));
        @(negedge clk);
        chk("idle", 14'h0001, 14'(idle));
        repeat (4) @(negedge clk);
        chk("ir", 14'h2947, ir);
        chk("valid", 14'h0001, 14'(irv));
    endtask
    task t_reset;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("phase", 14'h0001, 14'(phase));
        chk("valid", 14'h0000, 14'(irv));
        chk("idle", 14'h0000, 14'(idle));
        chk("addr", 14'h0000, 14'(addr));
        chk("acc", 14'h0000, 14'(acc));
        @(negedge clk);
        chk("ir", 14'h2800, ir);
        chk("valid", 14'h0001, 14'(irv));
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk("phase", 14'h0001, 14'(phase));
        chk("valid", 14'h0000, 14'(irv));
        @(negedge clk);
        chk("ir", 14'h2800, ir);
        t_alu();
        t_alu_ops();
        t_branch();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
